/* File: src/rivm_pkg.sv */
/*
 * Package for the reset and interrupt vector map: word addresses, table
 * offsets and the boot-section start.
 * Assumes a word-addressed program memory with a 12-bit fetch address.
 */
package rivm_pkg;

    // ****************************************************************
    // Widths and counts
    // ****************************************************************
    localparam int ADDR_W    = 12;
    localparam int NUM_IRQ   = 25;
    localparam int IRQ_IDX_W = 5;

    // ****************************************************************
    // Addresses
    // ****************************************************************
    localparam logic [ADDR_W-1:0] RESET_ADDR        = 12'h000;
    localparam logic [ADDR_W-1:0] TABLE_FIRST_OFS   = 12'h001;
    localparam logic [ADDR_W-1:0] BOOT_RESET_ADDR_D = 12'hc00;

    // ****************************************************************
    // Source indices, lowest index has the highest priority
    // ****************************************************************
    localparam int IDX_EXT_REQ_ZERO        = 0;
    localparam int IDX_EXT_REQ_ONE         = 1;
    localparam int IDX_PIN_CHANGE_ZERO     = 2;
    localparam int IDX_PIN_CHANGE_ONE      = 3;
    localparam int IDX_PIN_CHANGE_TWO      = 4;
    localparam int IDX_WATCHDOG_TIMEOUT    = 5;
    localparam int IDX_SECOND_TMR_MATCH_A  = 6;
    localparam int IDX_SECOND_TMR_MATCH_B  = 7;
    localparam int IDX_SECOND_TMR_OVF      = 8;
    localparam int IDX_WIDE_TMR_CAPTURE    = 9;
    localparam int IDX_WIDE_TMR_MATCH_A    = 10;
    localparam int IDX_WIDE_TMR_MATCH_B    = 11;
    localparam int IDX_WIDE_TMR_OVF        = 12;
    localparam int IDX_FIRST_TMR_MATCH_A   = 13;
    localparam int IDX_FIRST_TMR_MATCH_B   = 14;
    localparam int IDX_FIRST_TMR_OVF       = 15;
    localparam int IDX_SPI_XFER_COMPLETE   = 16;
    localparam int IDX_SERIAL_RX_COMPLETE  = 17;
    localparam int IDX_SERIAL_TX_BUF_EMPTY = 18;
    localparam int IDX_SERIAL_TX_COMPLETE  = 19;
    localparam int IDX_ADC_COMPLETE        = 20;
    localparam int IDX_EEPROM_READY        = 21;
    localparam int IDX_ANALOG_COMPARATOR   = 22;
    localparam int IDX_TWO_WIRE_SERIAL     = 23;
    localparam int IDX_STORE_PROGRAM_READY = 24;

    // ****************************************************************
    // Table offsets, one per source
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFS_EXT_REQ_ZERO        = 12'h001;
    localparam logic [ADDR_W-1:0] OFS_EXT_REQ_ONE         = 12'h002;
    localparam logic [ADDR_W-1:0] OFS_PIN_CHANGE_ZERO     = 12'h003;
    localparam logic [ADDR_W-1:0] OFS_PIN_CHANGE_ONE      = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PIN_CHANGE_TWO      = 12'h005;
    localparam logic [ADDR_W-1:0] OFS_WATCHDOG_TIMEOUT    = 12'h006;
    localparam logic [ADDR_W-1:0] OFS_SECOND_TMR_MATCH_A  = 12'h007;
    localparam logic [ADDR_W-1:0] OFS_SECOND_TMR_MATCH_B  = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_SECOND_TMR_OVF      = 12'h009;
    localparam logic [ADDR_W-1:0] OFS_WIDE_TMR_CAPTURE    = 12'h00a;
    localparam logic [ADDR_W-1:0] OFS_WIDE_TMR_MATCH_A    = 12'h00b;
    localparam logic [ADDR_W-1:0] OFS_WIDE_TMR_MATCH_B    = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_WIDE_TMR_OVF        = 12'h00d;
    localparam logic [ADDR_W-1:0] OFS_FIRST_TMR_MATCH_A   = 12'h00e;
    localparam logic [ADDR_W-1:0] OFS_FIRST_TMR_MATCH_B   = 12'h00f;
    localparam logic [ADDR_W-1:0] OFS_FIRST_TMR_OVF       = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_SPI_XFER_COMPLETE   = 12'h011;
    localparam logic [ADDR_W-1:0] OFS_SERIAL_RX_COMPLETE  = 12'h012;
    localparam logic [ADDR_W-1:0] OFS_SERIAL_TX_BUF_EMPTY = 12'h013;
    localparam logic [ADDR_W-1:0] OFS_SERIAL_TX_COMPLETE  = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_ADC_COMPLETE        = 12'h015;
    localparam logic [ADDR_W-1:0] OFS_EEPROM_READY        = 12'h016;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_COMPARATOR   = 12'h017;
    localparam logic [ADDR_W-1:0] OFS_TWO_WIRE_SERIAL     = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_STORE_PROGRAM_READY = 12'h019;

    // Fuse encoding: zero means programmed.
    localparam logic FUSE_PROGRAMMED = 1'b0;

endpackage

/* File: src/rivm_vector_map.sv */
/*
 * Reset and interrupt vector map: registered fetch address for reset and
 * for the highest-priority enabled pending request.
 * Assumes request lines and enables are synchronous to i_sys_clk and that
 * the CPU pulses i_irq_ack when it takes the offered vector.
 * Assumes the CPU drops the request line of a source it has serviced, and
 * that the fuse and the select bit change only while no offer stands.
 */
`timescale 1ns/1ps
module rivm_vector_map
    import rivm_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = BOOT_RESET_ADDR_D
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_boot_reset_fuse,
    input  wire logic                 i_vector_select_bit,
    input  wire logic                 i_global_irq_enable,
    input  wire logic [NUM_IRQ-1:0]   i_irq_request,
    input  wire logic [NUM_IRQ-1:0]   i_irq_enable,
    input  wire logic                 i_irq_ack,
    output logic                      o_reset_vector_valid,
    output logic                      o_irq_valid,
    output logic [IRQ_IDX_W-1:0]      o_irq_index,
    output logic [ADDR_W-1:0]         o_fetch_addr
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire logic rst_n = rst_sync_reg;

    // ****************************************************************
    // Priority selection
    // ****************************************************************
    logic [NUM_IRQ-1:0] pending;
    logic [NUM_IRQ-1:0] lower_pending;
    logic [NUM_IRQ-1:0] winner;

    assign pending = i_irq_request & i_irq_enable & {NUM_IRQ{i_global_irq_enable}};

    // Each source wins only if no lower-numbered source is pending.
    genvar g;
    generate
        for (g = 0; g < NUM_IRQ; g++) begin : g_prio
            if (g == 0) begin : g_first
                assign lower_pending[g] = 1'b0;
            end else begin : g_rest
                assign lower_pending[g] = lower_pending[g-1] | pending[g-1];
            end
            assign winner[g] = pending[g] & ~lower_pending[g];
        end
    endgenerate

    logic [IRQ_IDX_W-1:0] win_idx;

    always_comb begin
        win_idx = '0;
        for (int k = NUM_IRQ - 1; k >= 0; k--) begin
            if (winner[k]) begin
                win_idx = IRQ_IDX_W'(k);
            end
        end
    end

    wire logic any_pending = |pending;

    // ****************************************************************
    // Vector table
    // ****************************************************************
    // One table offset per source, in source order.
    localparam logic [ADDR_W-1:0] SRC_OFS [NUM_IRQ] = '{
        OFS_EXT_REQ_ZERO,
        OFS_EXT_REQ_ONE,
        OFS_PIN_CHANGE_ZERO,
        OFS_PIN_CHANGE_ONE,
        OFS_PIN_CHANGE_TWO,
        OFS_WATCHDOG_TIMEOUT,
        OFS_SECOND_TMR_MATCH_A,
        OFS_SECOND_TMR_MATCH_B,
        OFS_SECOND_TMR_OVF,
        OFS_WIDE_TMR_CAPTURE,
        OFS_WIDE_TMR_MATCH_A,
        OFS_WIDE_TMR_MATCH_B,
        OFS_WIDE_TMR_OVF,
        OFS_FIRST_TMR_MATCH_A,
        OFS_FIRST_TMR_MATCH_B,
        OFS_FIRST_TMR_OVF,
        OFS_SPI_XFER_COMPLETE,
        OFS_SERIAL_RX_COMPLETE,
        OFS_SERIAL_TX_BUF_EMPTY,
        OFS_SERIAL_TX_COMPLETE,
        OFS_ADC_COMPLETE,
        OFS_EEPROM_READY,
        OFS_ANALOG_COMPARATOR,
        OFS_TWO_WIRE_SERIAL,
        OFS_STORE_PROGRAM_READY
    };

    // Each offset, masked by its source's win flag, is merged into one word.
    // Only one win flag is set at a time, so the merge is a plain OR chain.
    logic [ADDR_W-1:0] masked_ofs [NUM_IRQ];
    logic [ADDR_W-1:0] merged_ofs [NUM_IRQ];

    generate
        for (g = 0; g < NUM_IRQ; g++) begin : g_ofs
            assign masked_ofs[g] = winner[g] ? SRC_OFS[g] : '0;
            if (g == 0) begin : g_first
                assign merged_ofs[g] = masked_ofs[g];
            end else begin : g_rest
                assign merged_ofs[g] = merged_ofs[g-1] | masked_ofs[g];
            end
        end
    endgenerate

    wire logic [ADDR_W-1:0] table_ofs = merged_ofs[NUM_IRQ-1];

    // ****************************************************************
    // Address formation
    // ****************************************************************

    // The select bit moves only the interrupt table, never the reset vector.
    wire logic [ADDR_W-1:0] table_base =
        i_vector_select_bit ? BOOT_RESET_ADDR : RESET_ADDR;

    wire logic [ADDR_W-1:0] irq_addr = table_base + table_ofs;

    wire logic [ADDR_W-1:0] reset_addr =
        (i_boot_reset_fuse == FUSE_PROGRAMMED) ? BOOT_RESET_ADDR : RESET_ADDR;

    // ****************************************************************
    // Output registers
    // ****************************************************************
    logic                 reset_pend_reg;
    logic                 irq_valid_reg;
    logic [IRQ_IDX_W-1:0] irq_index_reg;
    logic [ADDR_W-1:0]    fetch_addr_reg;
    logic [ADDR_W-1:0]    fetch_addr_next;

    // Reset vector is offered once after release, ahead of any request.
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pend_reg <= 1'b1;
        end else if (i_irq_ack) begin
            reset_pend_reg <= 1'b0;
        end
    end

    // An ack closes the current offer; the next one is formed a cycle later,
    // which gives the CPU time to drop the line it has just serviced.
    wire logic hold_reset = reset_pend_reg & ~i_irq_ack;
    wire logic offer_irq  = ~reset_pend_reg & any_pending & ~i_irq_ack;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_valid_reg <= 1'b0;
        end else begin
            irq_valid_reg <= offer_irq;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_index_reg <= '0;
        end else if (!hold_reset) begin
            irq_index_reg <= win_idx;
        end
    end

    // Reset address while the reset vector waits, new vector on an offer.
    always_comb begin
        if (hold_reset) begin
            fetch_addr_next = reset_addr;
        end else if (offer_irq) begin
            fetch_addr_next = irq_addr;
        end else begin
            fetch_addr_next = fetch_addr_reg;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr_reg <= RESET_ADDR;
        end else begin
            fetch_addr_reg <= fetch_addr_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_reset_vector_valid = reset_pend_reg & rst_n;
    assign o_irq_valid          = irq_valid_reg;
    assign o_irq_index          = irq_index_reg;
    assign o_fetch_addr         = fetch_addr_reg;

endmodule

/* File: test/rivm_vector_map_chk.sv */
/* Port assertions for rivm_vector_map.
   Bound to every instance; sees only its ports. */
`timescale 1ns/1ps
module rivm_vector_map_chk
    import rivm_pkg::*;
#(parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = BOOT_RESET_ADDR_D) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_boot_reset_fuse,
    input wire logic i_vector_select_bit,
    input wire logic i_global_irq_enable,
    input wire logic [NUM_IRQ-1:0] i_irq_request,
    input wire logic [NUM_IRQ-1:0] i_irq_enable,
    input wire logic i_irq_ack,
    input wire logic o_reset_vector_valid,
    input wire logic o_irq_valid,
    input wire logic [IRQ_IDX_W-1:0] o_irq_index,
    input wire logic [ADDR_W-1:0] o_fetch_addr
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    wire [NUM_IRQ-1:0] pend = i_irq_request & i_irq_enable;
    reset_addr_a: assert property (o_reset_vector_valid && $past(o_reset_vector_valid)
        |-> o_fetch_addr == (i_boot_reset_fuse ? RESET_ADDR : BOOT_RESET_ADDR)) else $error("rst");
    vector_addr_a: assert property (o_irq_valid |-> o_fetch_addr ==
        ($past(i_vector_select_bit) ? BOOT_RESET_ADDR : RESET_ADDR) + TABLE_FIRST_OFS
        + ADDR_W'(o_irq_index)) else $error("vector");
    lowest_wins_a: assert property (o_irq_valid |->
        ($past(pend) & ((NUM_IRQ'(2) << o_irq_index) - NUM_IRQ'(1)))
        == NUM_IRQ'(1) << o_irq_index) else $error("priority");
    reset_first_a: assert property (o_reset_vector_valid |-> !o_irq_valid) else $error("order");
    offer_next_a: assert property (pend != '0 && i_global_irq_enable && !i_irq_ack
        && !o_reset_vector_valid |=> o_irq_valid) else $error("no offer");
    gate_off_a: assert property (!i_global_irq_enable |=> !o_irq_valid)
        else $error("gated");
    irq_ack_a: assert property (i_irq_ack && o_irq_valid |=> !o_irq_valid)
        else $error("ack");
    reset_ack_a: assert property (i_irq_ack && o_reset_vector_valid |=> !o_reset_vector_valid)
        else $error("rst ack");
endmodule
bind rivm_vector_map rivm_vector_map_chk #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) u_chk (.i_sys_clk,
    .i_arst_n, .i_boot_reset_fuse, .i_vector_select_bit, .i_global_irq_enable, .i_irq_request,
    .i_irq_enable, .i_irq_ack, .o_reset_vector_valid, .o_irq_valid, .o_irq_index, .o_fetch_addr);

/* File: test/rivm_cpu_model.sv */
/* CPU side: holds request lines, acks each offer after 0 to 3 cycles.
   Assumes offer inputs come straight from the vector map. */
`timescale 1ns/1ps
module rivm_cpu_model
    import rivm_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_offer,
    input  wire logic                 i_irq_valid,
    input  wire logic [IRQ_IDX_W-1:0] i_irq_index,
    input  wire logic [NUM_IRQ-1:0]   i_raise,
    output logic                      o_ack,
    output logic [NUM_IRQ-1:0]        o_request
);
    logic [1:0] wait_reg;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ack <= 1'b0;
            o_request <= '0;
            wait_reg <= 2'h3;
        end else begin
            o_request <= o_request | i_raise;
            o_ack <= i_offer && !o_ack && wait_reg == 2'h0;
            wait_reg <= o_ack ? 2'($urandom) : wait_reg - 2'(wait_reg != 2'h0);
            // The serviced source drops its line so it is not offered twice.
            if (o_ack && i_irq_valid) o_request[i_irq_index] <= 1'b0;
        end
    end
endmodule

/* File: test/rivm_vector_map_tb_top.sv */
/* Self-checking bench for rivm_vector_map.
   Assumes the package, checker and CPU model are compiled first. */
`timescale 1ns/1ps
module rivm_vector_map_tb_top;
    import rivm_pkg::*;
    logic                 clk = 1'b0, rst_n = 1'b0, fuse = 1'b1, sel = 1'b0, gie = 1'b0;
    logic                 ack, rv, iv, s;
    logic [NUM_IRQ-1:0]   en = '1, raise = '0, req, m;
    logic [IRQ_IDX_W-1:0] idx;
    logic [ADDR_W-1:0]    addr;
    int                   num_errors = 0, check_count = 0, cyc = 0;
    rivm_vector_map dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_boot_reset_fuse(fuse),
        .i_vector_select_bit(sel), .i_global_irq_enable(gie), .i_irq_request(req),
        .i_irq_enable(en), .i_irq_ack(ack), .o_reset_vector_valid(rv), .o_irq_valid(iv),
        .o_irq_index(idx), .o_fetch_addr(addr));
    rivm_cpu_model cpu (.i_sys_clk(clk), .i_arst_n(rst_n), .i_offer(rv | iv), .i_irq_valid(iv),
        .i_irq_index(idx), .i_raise(raise), .o_ack(ack), .o_request(req));
    function automatic logic [ADDR_W-1:0] vec(input logic vs, input logic [NUM_IRQ-1:0] mk);
        int k;
        for (k = 0; k < NUM_IRQ - 1 && !mk[k]; k++) begin
        end
        return (vs ? BOOT_RESET_ADDR_D : RESET_ADDR) + TABLE_FIRST_OFS + ADDR_W'(k);
    endfunction
    task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] want);
        check_count++;
        if (got !== want) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // Waits for the edge that takes an offer and checks the address offered there.
    task automatic take(input logic [ADDR_W-1:0] want);
        int n = 0;
        do @(posedge clk); while (ack !== 1'b1 && ++n < 100);
        chk(addr, want);
    endtask
    task automatic fire(input logic [NUM_IRQ-1:0] mk);
        raise <= mk;
        @(posedge clk);
        raise <= '0;
    endtask
    task automatic rst(input logic f);
        rst_n <= 1'b0;
        fuse <= f;
        gie <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        take(f ? RESET_ADDR : BOOT_RESET_ADDR_D);
        chk(ADDR_W'(rv), ADDR_W'(1));
        gie <= 1'b1;
    endtask
    task automatic sweep;
        for (int k = 0; k < NUM_IRQ; k++) begin
            s = 1'($urandom);
            sel <= s;
            fire(NUM_IRQ'(1) << k);
            take(vec(s, NUM_IRQ'(1) << k));
            chk(ADDR_W'(idx), ADDR_W'(k));
        end
        for (int r = 0; r < 6; r++) begin
            m = r ? NUM_IRQ'($urandom) | NUM_IRQ'(1) << (r * 4) : '1;
            fire(m);
            for (; m != '0; m &= m - NUM_IRQ'(1)) take(vec(s, m));
        end
        for (int g = 0; g < 2; g++) begin
            gie <= g[0] ? 1'b0 : 1'b1;
            en <= g[0] ? '1 : ~NUM_IRQ'(8);
            fire(NUM_IRQ'(8));
            repeat (8) @(posedge clk);
            chk(ADDR_W'(iv), '0);
            gie <= 1'b1;
            en <= '1;
            take(vec(s, NUM_IRQ'(8)));
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(20));
        @(posedge clk);
        rst(1'b1);
        sweep();
        rst(1'b0);
        sweep();
        wrap_up();
    end
endmodule
